// *** suspend_resume_power_down_gate.sv ***
`include "flash_gate_consts.svh"
`default_nettype none
module suspend_resume_power_down_gate
    import flash_gate_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       en_i,
    // Host link pins
    input  wire logic       cs_n_i,
    input  wire logic       sck_i,
    input  wire logic [3:0] io_i,
    // Write engine side
    input  wire logic       four_bit_command_mode_i,
    input  wire logic       write_in_progress_i,
    input  wire logic       erase_busy_i,
    input  wire logic       program_busy_i,
    input  wire logic       chip_erase_busy_i,
    input  wire logic       engine_done_i,
    // Command decisions
    output logic      [7:0] opcode_o,
    output logic            opcode_valid_o,
    output logic            opcode_ignored_o,
    output logic            resume_o,
    output logic            suspend_erase_o,
    output logic            suspend_program_o,
    output logic            soft_reset_o,
    // Status
    output logic            erase_suspended_flag_o,
    output logic            program_suspended_flag_o,
    output logic      [7:0] function_suspend_bits_o,
    output logic            write_enable_latch_o,
    output logic            write_in_progress_o,
    output logic            power_down_o
);

    // ****************************************************************
    // Opcode classes
    // ****************************************************************

    function automatic logic is_read_op(input logic [7:0] op);
        is_read_op = (op == `OP_RD_NORMAL)   || (op == `OP_RD_FAST)
                  || (op == `OP_RD_DUAL_IO)  || (op == `OP_RD_DUAL_OUT)
                  || (op == `OP_RD_QUAD_IO)  || (op == `OP_RD_QUAD_OUT)
                  || (op == `OP_RD_DTR)      || (op == `OP_RD_DUAL_DTR)
                  || (op == `OP_RD_QUAD_DTR);
    endfunction

    function automatic logic is_suspend_op(input logic [7:0] op);
        is_suspend_op = (op == `OP_SUSPEND_A) || (op == `OP_SUSPEND_B);
    endfunction

    function automatic logic is_resume_op(input logic [7:0] op);
        is_resume_op = (op == `OP_RESUME_A) || (op == `OP_RESUME_B);
    endfunction

    function automatic logic is_erase_only_op(input logic [7:0] op);
        is_erase_only_op = (op == `OP_PP_SERIAL) || (op == `OP_PP_QUAD_A)
                        || (op == `OP_PP_QUAD_B) || (op == `OP_WREN)
                        || is_suspend_op(op)
                        || (op == `OP_SEC_UNLOCK) || (op == `OP_SEC_LOCK);
    endfunction

    function automatic logic is_common_op(input logic [7:0] op);
        is_common_op = (op == `OP_RD_STATUS)    || (op == `OP_RD_FUNC)
                    || (op == `OP_ERR_CLEAR)    || is_resume_op(op)
                    || (op == `OP_RELEASE_ID)   || (op == `OP_RD_JEDEC)
                    || (op == `OP_RD_MFR_DEV)   || (op == `OP_RD_JEDEC_Q)
                    || (op == `OP_RD_PARAM_TBL) || (op == `OP_RD_UID)
                    || (op == `OP_RD_INFO_ROW)  || (op == `OP_RD_BOOT_REG)
                    || (op == `OP_SET_VPAR_A)   || (op == `OP_SET_VPAR_B)
                    || (op == `OP_SET_VEPAR)    || (op == `OP_RD_PAR)
                    || (op == `OP_RD_EPAR)      || (op == `OP_NOP)
                    || (op == `OP_RESET_EN)     || (op == `OP_RESET);
    endfunction

    // Whether the current mode lets an opcode through
    function automatic logic op_allowed(input logic [7:0]   op,
                                        input logic         erase_suspended_flag,
                                        input logic         program_suspended_flag,
                                        input pd_state_type pd,
                                        input logic         write_in_progress);
        logic ok;
        ok = 1'b1;
        if (pd != PD_ACTIVE)
            ok = (op == `OP_RELEASE_ID);
        else if (erase_suspended_flag || program_suspended_flag)
            ok = is_read_op(op)
              || (erase_suspended_flag && !program_suspended_flag && is_erase_only_op(op))
              || is_common_op(op);
        if ((op == `OP_RELEASE_ID) && write_in_progress)
            ok = 1'b0;
        op_allowed = ok;
    endfunction

    // ****************************************************************
    // Pin synchronisers and opcode capture
    // ****************************************************************

    logic [5:0] pins_s;
    logic       cs_n_s;
    logic [4:0] bit_count;
    logic [7:0] shifted_op;
    logic       op_latched;

    pin_sync #(
        .WIDTH (6)
    ) u_pin_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .en_i      (en_i),
        .pin_i     ({cs_n_i, sck_i, io_i}),
        .sync_o    (pins_s)
    );

    assign cs_n_s = pins_s[5];

    opcode_shifter u_opcode_shifter (
        .clk_sys_i     (clk_sys_i),
        .rst_n_i       (rst_n_i),
        .en_i          (en_i),
        .cs_n_s_i      (cs_n_s),
        .sck_s_i       (pins_s[4]),
        .io_s_i        (pins_s[3:0]),
        .nibble_mode_i (four_bit_command_mode_i),
        .opcode_o      (shifted_op),
        .bit_count_o   (bit_count),
        .latched_o     (op_latched)
    );

    // ****************************************************************
    // Command state
    // ****************************************************************

    pd_state_type pd_state_q;
    pd_state_type pd_state_d;
    logic [9:0]   pd_cnt_q;
    logic [9:0]   pd_cnt_d;
    logic         cs_prev_q;
    logic         cs_prev_d;
    logic         accepted_q;
    logic         accepted_d;
    logic         rst_armed_q;
    logic         rst_armed_d;
    logic         erase_suspended_flag_q;
    logic         erase_suspended_flag_d;
    logic         program_suspended_flag_q;
    logic         program_suspended_flag_d;
    logic         wel_q;
    logic         wel_d;
    logic         wip_q;
    logic         wip_d;
    logic [7:0]   opcode_q;
    logic [7:0]   opcode_d;
    logic         valid_q;
    logic         valid_d;
    logic         ignored_q;
    logic         ignored_d;
    logic         resume_q;
    logic         resume_d;
    logic         sus_e_q;
    logic         sus_e_d;
    logic         sus_p_q;
    logic         sus_p_d;
    logic         srst_q;
    logic         srst_d;
    logic         cs_rise;
    logic         frame_exact;

    always_comb
    begin
        cs_rise     = cs_n_s && !cs_prev_q;
        // Standalone opcodes act only when the frame held exactly one opcode cycle
        frame_exact = (bit_count == `BITS_PER_OP);
        pd_state_d  = pd_state_q;
        pd_cnt_d    = pd_cnt_q;
        cs_prev_d   = cs_prev_q;
        accepted_d  = accepted_q;
        rst_armed_d = rst_armed_q;
        erase_suspended_flag_d      = erase_suspended_flag_q;
        program_suspended_flag_d      = program_suspended_flag_q;
        wel_d       = wel_q;
        wip_d       = wip_q;
        opcode_d    = opcode_q;
        valid_d     = valid_q && !en_i;
        ignored_d   = ignored_q && !en_i;
        resume_d    = resume_q && !en_i;
        sus_e_d     = sus_e_q && !en_i;
        sus_p_d     = sus_p_q && !en_i;
        srst_d      = srst_q && !en_i;
        if (en_i)
        begin
            cs_prev_d = cs_n_s;
            wip_d     = write_in_progress_i;
            if (engine_done_i)
                wel_d = 1'b0;
            if (op_latched)
            begin
                opcode_d   = shifted_op;
                accepted_d = op_allowed(shifted_op, erase_suspended_flag_q, program_suspended_flag_q, pd_state_q, wip_q);
                valid_d    = accepted_d;
                ignored_d  = !accepted_d;
            end
            if (cs_rise)
            begin
                accepted_d = 1'b0;
                if (accepted_q && frame_exact)
                begin
                    rst_armed_d = (opcode_q == `OP_RESET_EN);
                    if (is_resume_op(opcode_q))
                    begin
                        // Latest suspension is undone first
                        resume_d = erase_suspended_flag_q || program_suspended_flag_q;
                        if (program_suspended_flag_q)
                            program_suspended_flag_d = 1'b0;
                        else
                            erase_suspended_flag_d = 1'b0;
                    end
                    else if (is_suspend_op(opcode_q))
                    begin
                        if (program_busy_i && !program_suspended_flag_q)
                        begin
                            program_suspended_flag_d  = 1'b1;
                            wel_d   = 1'b0;
                            sus_p_d = 1'b1;
                        end
                        else if (erase_busy_i && !chip_erase_busy_i && !erase_suspended_flag_q)
                        begin
                            erase_suspended_flag_d  = 1'b1;
                            wel_d   = 1'b0;
                            sus_e_d = 1'b1;
                        end
                    end
                    else if (opcode_q == `OP_WREN)
                        wel_d = 1'b1;
                    else if (opcode_q == `OP_WRDI)
                        wel_d = 1'b0;
                    else if ((opcode_q == `OP_RESET) && rst_armed_q)
                    begin
                        srst_d = 1'b1;
                        erase_suspended_flag_d = 1'b0;
                        program_suspended_flag_d = 1'b0;
                        wel_d  = 1'b0;
                    end
                    else if ((opcode_q == `OP_PD_ENTRY) && (pd_state_q == PD_ACTIVE))
                    begin
                        pd_state_d = PD_ENTERING;
                        pd_cnt_d   = 10'(`PD_ENTRY_CYCLES);
                    end
                    else if ((opcode_q == `OP_RELEASE_ID) && (pd_state_q != PD_ACTIVE))
                        pd_state_d = PD_ACTIVE;
                end
                else
                    rst_armed_d = 1'b0;
            end
            unique case (pd_state_q)
                PD_ACTIVE:
                    ;
                PD_ENTERING:
                begin
                    if (pd_state_d == PD_ENTERING)
                    begin
                        if (pd_cnt_q <= `PD_CNT_ONE)
                            pd_state_d = PD_DOWN;
                        else
                            pd_cnt_d = pd_cnt_q - `PD_CNT_ONE;
                    end
                end
                PD_DOWN:
                    ;
                default:
                    pd_state_d = PD_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pd_state_q  <= PD_ACTIVE;
            pd_cnt_q    <= `PD_CNT_ZERO;
            cs_prev_q   <= 1'b1;
            accepted_q  <= 1'b0;
            rst_armed_q <= 1'b0;
            erase_suspended_flag_q      <= 1'b0;
            program_suspended_flag_q      <= 1'b0;
            wel_q       <= 1'b0;
            wip_q       <= 1'b0;
            opcode_q    <= 8'h00;
            valid_q     <= 1'b0;
            ignored_q   <= 1'b0;
            resume_q    <= 1'b0;
            sus_e_q     <= 1'b0;
            sus_p_q     <= 1'b0;
            srst_q      <= 1'b0;
        end
        else
        begin
            pd_state_q  <= pd_state_d;
            pd_cnt_q    <= pd_cnt_d;
            cs_prev_q   <= cs_prev_d;
            accepted_q  <= accepted_d;
            rst_armed_q <= rst_armed_d;
            erase_suspended_flag_q      <= erase_suspended_flag_d;
            program_suspended_flag_q      <= program_suspended_flag_d;
            wel_q       <= wel_d;
            wip_q       <= wip_d;
            opcode_q    <= opcode_d;
            valid_q     <= valid_d;
            ignored_q   <= ignored_d;
            resume_q    <= resume_d;
            sus_e_q     <= sus_e_d;
            sus_p_q     <= sus_p_d;
            srst_q      <= srst_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    always_comb
    begin
        function_suspend_bits_o                 = `FUNC_RESET_VAL;
        function_suspend_bits_o[`FUNC_PROGRAM_SUSPENDED_FLAG_BIT] = program_suspended_flag_q;
        function_suspend_bits_o[`FUNC_ERASE_SUSPENDED_FLAG_BIT] = erase_suspended_flag_q;
    end

    assign opcode_o                 = opcode_q;
    assign opcode_valid_o           = valid_q;
    assign opcode_ignored_o         = ignored_q;
    assign resume_o                 = resume_q;
    assign suspend_erase_o          = sus_e_q;
    assign suspend_program_o        = sus_p_q;
    assign soft_reset_o             = srst_q;
    assign erase_suspended_flag_o   = erase_suspended_flag_q;
    assign program_suspended_flag_o = program_suspended_flag_q;
    assign write_enable_latch_o     = wel_q;
    assign write_in_progress_o      = wip_q;
    assign power_down_o             = (pd_state_q == PD_DOWN);

endmodule
`default_nettype wire

// *** flash_gate_consts.svh ***
`ifndef FLASH_GATE_CONSTS_SVH
`define FLASH_GATE_CONSTS_SVH

// Opcodes
`define OP_RESUME_A     8'h7a
`define OP_RESUME_B     8'h30
`define OP_SUSPEND_A    8'h75
`define OP_SUSPEND_B    8'hb0
`define OP_PD_ENTRY     8'hb9
`define OP_RELEASE_ID   8'hab
`define OP_RESET_EN     8'h66
`define OP_RESET        8'h99
`define OP_WREN         8'h06
`define OP_WRDI         8'h04
`define OP_NOP          8'h00
`define OP_RD_NORMAL    8'h03
`define OP_RD_FAST      8'h0b
`define OP_RD_DUAL_IO   8'hbb
`define OP_RD_DUAL_OUT  8'h3b
`define OP_RD_QUAD_IO   8'heb
`define OP_RD_QUAD_OUT  8'h6b
`define OP_RD_DTR       8'h0d
`define OP_RD_DUAL_DTR  8'hbd
`define OP_RD_QUAD_DTR  8'hed
`define OP_PP_SERIAL    8'h02
`define OP_PP_QUAD_A    8'h32
`define OP_PP_QUAD_B    8'h38
`define OP_SEC_UNLOCK   8'h26
`define OP_SEC_LOCK     8'h24
`define OP_RD_STATUS    8'h05
`define OP_RD_FUNC      8'h48
`define OP_ERR_CLEAR    8'h82
`define OP_RD_JEDEC     8'h9f
`define OP_RD_MFR_DEV   8'h90
`define OP_RD_JEDEC_Q   8'haf
`define OP_RD_UID       8'h4b
`define OP_RD_PARAM_TBL 8'h5a
`define OP_RD_INFO_ROW  8'h68
`define OP_RD_BOOT_REG  8'h14
`define OP_SET_VPAR_A   8'hc0
`define OP_SET_VPAR_B   8'h63
`define OP_SET_VEPAR    8'h83
`define OP_RD_PAR       8'h61
`define OP_RD_EPAR      8'h81

// Function register layout
`define FUNC_PROGRAM_SUSPENDED_FLAG_BIT   2
`define FUNC_ERASE_SUSPENDED_FLAG_BIT   3
`define FUNC_RESET_VAL  8'h00

// Opcode shifting
`define BITS_PER_OP     5'h08
`define STEP_SERIAL     5'h01
`define STEP_NIBBLE     5'h04
`define BIT_COUNT_MAX   5'h1f

// Timing
`define CLK_PERIOD_NS   4
`define PD_ENTRY_NS     3000
`define PD_ENTRY_CYCLES ((`PD_ENTRY_NS) / (`CLK_PERIOD_NS))
`define PD_CNT_ZERO     10'h000
`define PD_CNT_ONE      10'h001

`endif

// *** flash_gate_pkg.sv ***
`default_nettype none
package flash_gate_pkg;

    typedef enum logic [2:0] {
        PD_ACTIVE   = 3'b001,
        PD_ENTERING = 3'b010,
        PD_DOWN     = 3'b100
    } pd_state_type;

endpackage
`default_nettype wire

// *** pin_sync.sv ***
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic             en_i,
    // Pins
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb
    begin
        meta_d = en_i ? pin_i : meta_q;
        sync_d = en_i ? meta_q : sync_q;
    end

    // Stage one feeds only stage two
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '1;
            sync_q <= '1;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule
`default_nettype wire

// *** opcode_shifter.sv ***
`include "flash_gate_consts.svh"
`default_nettype none
module opcode_shifter (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       en_i,
    // Synchronised link
    input  wire logic       cs_n_s_i,
    input  wire logic       sck_s_i,
    input  wire logic [3:0] io_s_i,
    input  wire logic       nibble_mode_i,
    // Opcode out
    output logic      [7:0] opcode_o,
    output logic      [4:0] bit_count_o,
    output logic            latched_o
);

    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [4:0] count_q;
    logic [4:0] count_d;
    logic       sck_prev_q;
    logic       sck_prev_d;
    logic       latched_q;
    logic       latched_d;
    logic       rise;
    logic [5:0] sum;
    logic [4:0] step;

    always_comb
    begin
        rise       = sck_s_i && !sck_prev_q;
        step       = nibble_mode_i ? `STEP_NIBBLE : `STEP_SERIAL;
        sum        = {1'b0, count_q} + {1'b0, step};
        sck_prev_d = sck_prev_q;
        shift_d    = shift_q;
        count_d    = count_q;
        latched_d  = latched_q && !en_i;
        if (en_i)
        begin
            sck_prev_d = sck_s_i;
            if (cs_n_s_i)
            begin
                count_d = 5'h00;
            end
            else if (rise)
            begin
                // Opcode bits only matter up to the first byte
                if (count_q < `BITS_PER_OP)
                begin
                    if (nibble_mode_i)
                        shift_d = {shift_q[3:0], io_s_i};
                    else
                        shift_d = {shift_q[6:0], io_s_i[0]};
                end
                count_d   = sum[5] ? `BIT_COUNT_MAX : sum[4:0];
                latched_d = (count_q < `BITS_PER_OP) && (sum[4:0] >= `BITS_PER_OP);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            shift_q    <= 8'h00;
            count_q    <= 5'h00;
            // Synchroniser resets high too, so no false edge follows reset
            sck_prev_q <= 1'b1;
            latched_q  <= 1'b0;
        end
        else
        begin
            shift_q    <= shift_d;
            count_q    <= count_d;
            sck_prev_q <= sck_prev_d;
            latched_q  <= latched_d;
        end
    end

    assign opcode_o    = shift_q;
    assign bit_count_o = count_q;
    assign latched_o   = latched_q;

endmodule
`default_nettype wire

// *** suspend_resume_power_down_gate_assertions.sv ***
`default_nettype none
module srpg_assertions (
    // Clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    input wire logic       en_i,
    // Engine side
    input wire logic       write_in_progress_i,
    input wire logic       chip_erase_busy_i,
    // Decisions and status
    input wire logic [7:0] opcode_o,
    input wire logic       opcode_valid_o,
    input wire logic       opcode_ignored_o,
    input wire logic       resume_o,
    input wire logic       suspend_erase_o,
    input wire logic       suspend_program_o,
    input wire logic       soft_reset_o,
    input wire logic       erase_suspended_flag_o,
    input wire logic       program_suspended_flag_o,
    input wire logic [7:0] function_suspend_bits_o,
    input wire logic       write_enable_latch_o,
    input wire logic       write_in_progress_o,
    input wire logic       power_down_o
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    AST_FUNC_BITS: assert property (function_suspend_bits_o ==
        {4'h0, erase_suspended_flag_o, program_suspended_flag_o, 2'h0}) else $error("func bits");
    // Guarded so the first edge after reset does not compare against reset-time input
    AST_WIP_ECHO: assert property ($past(rst_n_i) && $past(en_i) |->
        write_in_progress_o == $past(write_in_progress_i)) else $error("wip echo");
    AST_RESUME_CLEARS: assert property (resume_o && $past(en_i) |->
        $fell(program_suspended_flag_o) || $fell(erase_suspended_flag_o)) else $error("resume");
    AST_SUSPEND_SETS: assert property (suspend_erase_o || suspend_program_o |->
        !write_enable_latch_o && (suspend_erase_o ? erase_suspended_flag_o
        : program_suspended_flag_o)) else $error("suspend");
    AST_CHIP_ERASE: assert property (chip_erase_busy_i [*8] |->
        !suspend_erase_o && !suspend_program_o) else $error("chip erase suspend");
    AST_PD_ONLY_RELEASE: assert property (power_down_o && opcode_valid_o |->
        opcode_o == 8'hab) else $error("pd accept");
    AST_PD_ENTRY: assert property ($rose(power_down_o) |-> opcode_o == 8'hb9)
        else $error("pd entry");
    AST_PD_EXIT: assert property ($fell(power_down_o) |->
        opcode_o == 8'hab && !write_in_progress_o) else $error("pd exit");
    AST_PROGRAM_SUSPENDED_FLAG_REFUSE: assert property (program_suspended_flag_o && !erase_suspended_flag_o
        && opcode_valid_o |-> !(opcode_o inside {8'h02, 8'h32, 8'h38, 8'h06, 8'h75, 8'hb0,
        8'h26, 8'h24})) else $error("program_suspended_flag accept");
    AST_RESET_OP: assert property (soft_reset_o |-> opcode_o == 8'h99)
        else $error("reset op");
    AST_ONE_VERDICT: assert property (!(opcode_valid_o && opcode_ignored_o))
        else $error("verdict");
endmodule
bind suspend_resume_power_down_gate srpg_assertions u_chk (.*);
`default_nettype wire

// *** flash_host_model.sv ***
`default_nettype none
module flash_host_model (
    // Clock
    input  wire logic       clk_sys_i,
    // Link pins
    output logic            cs_n_o,
    output logic            sck_o,
    output logic      [3:0] io_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Framing
    // ****************************************
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        io_o = 4'h0;
    end
    // Half of a 64 ns link period
    task automatic half();
        repeat (8) @(negedge clk_sys_i);
    endtask
    task automatic frame(input logic [7:0] op, input logic nib, input int units);
        int i;
        half();
        cs_n_o = 1'b0;
        for (i = 0; i < units; i++)
        begin
            io_o = nib ? ((i % 2) ? op[3:0] : op[7:4]) : {3'h0, op[7 - (i % 8)]};
            half();
            sck_o = 1'b1;
            half();
            sck_o = 1'b0;
        end
        half();
        cs_n_o = 1'b1;
        // Released lines must not keep the last value
        io_o = ~io_o;
        half();
    endtask
endmodule
`default_nettype wire

// *** suspend_resume_power_down_gate_tb_top.sv ***
`default_nettype none
module suspend_resume_power_down_gate_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys_i = 1'b0, rst_n_i = 1'b0, en_i = 1'b1, engine_done_i = 1'b0;
    logic       cs_n_i, sck_i, four_bit_command_mode_i = 1'b0, write_in_progress_i = 1'b0;
    logic       erase_busy_i = 1'b0, program_busy_i = 1'b0, chip_erase_busy_i = 1'b0;
    logic [3:0] io_i;
    logic [4:0] seen = 5'h00;
    logic       clr_seen = 1'b0;
    logic [7:0] opcode_o, function_suspend_bits_o;
    logic       opcode_valid_o, opcode_ignored_o, resume_o, suspend_erase_o, suspend_program_o;
    logic       soft_reset_o, erase_suspended_flag_o, program_suspended_flag_o;
    logic       write_enable_latch_o, write_in_progress_o, power_down_o;
    int         failures = 0, comparisons = 0, cycles = 0, ph, u;
    // Opcode, accepted in erase suspend (bit 1), accepted in program suspend (bit 0)
    logic [11:0] rows [36] = '{12'h033, 12'h0b3, 12'hbb3, 12'h3b3, 12'heb3, 12'h6b3, 12'h0d3,
        12'hbd3, 12'hed3, 12'h022, 12'h322, 12'h382, 12'h062, 12'h262, 12'h242, 12'h053,
        12'h483, 12'h823, 12'h9f3, 12'h903, 12'haf3, 12'h4b3, 12'h5a3, 12'h003, 12'h663,
        12'h683, 12'h143, 12'hc03, 12'h633, 12'h833, 12'h613, 12'h813, 12'hab3, 12'h200,
        12'hc70, 12'h010};
    suspend_resume_power_down_gate u_dut (.*);
    flash_host_model u_host (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n_i), .sck_o(sck_i), .io_o(io_i));
    always #2 clk_sys_i = ~clk_sys_i;
    // ****************************************
    // Helpers
    // ****************************************
    task automatic end_sim();
        if (failures == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Seen pulses: suspend, valid, ignored, resume, soft reset
    always @(posedge clk_sys_i)
    begin
        cycles++;
        seen <= clr_seen ? 5'h00 : seen | {suspend_erase_o | suspend_program_o,
            opcode_valid_o, opcode_ignored_o, resume_o, soft_reset_o};
        if (cycles == 30000)
        begin
            failures++;
            end_sim();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] op, input int n);
        clr_seen = 1'b1;
        @(negedge clk_sys_i);
        clr_seen = 1'b0;
        u_host.frame(op, four_bit_command_mode_i, n);
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        repeat (12) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        check(opcode_o, 8'h00);
        check(function_suspend_bits_o, 8'h00);
        check(power_down_o, 1'b0);
        chip_erase_busy_i = 1'b1;
        erase_busy_i = 1'b1;
        write_in_progress_i = 1'b1;
        send(8'h75, 8);
        check(erase_suspended_flag_o, 1'b0);
        check(seen[4], 1'b0);
        check(write_in_progress_o, 1'b1);
        chip_erase_busy_i = 1'b0;
        // Only program suspend follows the erase resume, so no resume-to-suspend wait
        for (ph = 0; ph < 2; ph++)
        begin
            four_bit_command_mode_i = ph[0];
            u = ph ? 2 : 8;
            erase_busy_i = !ph[0];
            program_busy_i = ph[0];
            write_in_progress_i = 1'b1;
            send(8'h06, u);
            check(write_enable_latch_o, 1'b1);
            check(opcode_o, 8'h06);
            send(ph ? 8'hb0 : 8'h75, u);
            check(seen[4], 1'b1);
            check(ph ? program_suspended_flag_o : erase_suspended_flag_o, 1'b1);
            check(write_enable_latch_o, 1'b0);
            check(function_suspend_bits_o, ph ? 8'h04 : 8'h08);
            write_in_progress_i = 1'b0;
            foreach (rows[i])
            begin
                send(rows[i][11:4], u);
                check(seen[3], rows[i][1 - ph]);
                check(seen[2], !rows[i][1 - ph]);
            end
            send(ph ? 8'h30 : 8'h7a, u);
            check(seen[1], 1'b1);
            check(function_suspend_bits_o, 8'h00);
            erase_busy_i = 1'b0;
            program_busy_i = 1'b0;
        end
        four_bit_command_mode_i = 1'b0;
        send(8'h99, 8);
        check(seen[0], 1'b0);
        send(8'h66, 8);
        send(8'h99, 8);
        check(seen[0], 1'b1);
        send(8'hb9, 9);
        repeat (800) @(negedge clk_sys_i);
        check(power_down_o, 1'b0);
        four_bit_command_mode_i = 1'b1;
        send(8'hb9, 2);
        repeat (730) @(negedge clk_sys_i);
        check(power_down_o, 1'b0);
        repeat (30) @(negedge clk_sys_i);
        check(power_down_o, 1'b1);
        send(8'h05, 2);
        check(seen[2], 1'b1);
        write_in_progress_i = 1'b1;
        send(8'hab, 2);
        check(power_down_o, 1'b1);
        write_in_progress_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        send(8'hab, 2);
        check(power_down_o, 1'b0);
        four_bit_command_mode_i = 1'b0;
        send(8'hb9, 8);
        repeat (760) @(negedge clk_sys_i);
        check(power_down_o, 1'b1);
        end_sim();
    end
endmodule
`default_nettype wire
